/* File: verilog/brp_predictor.sv */
// Purpose: Branch direction, target and return prediction at predecode.
// Assumes: Execute pipeline reports each resolved conditional branch once.
// Notes: Fetch FIFOs and memory-side fetch are outside this block.
// Function
// (RULE1) 256-entry global pattern table indexed by recent outcome history.
// (RULE2) Each entry is a 2-bit hint giving taken or not-taken.
// (RULE3) Hint saturates up on taken, down on not-taken; top bit predicts.
// (RULE4) Loop counter up to 31 predicts exit; above 31 never not-taken.
// (RULE5) Detect aliasing onto one hint and add hysteresis before flipping.
// (RULE6) Direct branch target is program counter plus encoded offset.
// (RULE7) No computable or stacked target: predict not-taken, fetch sequentially.
// (RULE8) History and hint update when execute reports the resolution.
// (RULE9) Policy bits [16:15]: 00 dynamic, 01 all taken, 10 none taken.
// (RULE10) Control bit [21] disables loop-count prediction.
// (RULE11) Control bit [20] disables register extension cache prediction.
// (RULE12) Flow enable bit [11] always reads one; writes ignored.
// (RULE13) Software disables prediction via return stack off and not-taken policy; unconditional branches with a known target still redirect.
// (RULE14) Predict at predecode and redirect fetch on predicted-taken branches.
// (RULE15) Mismatch at writeback flushes pipeline and refetches correct stream.
// (RULE16) Unconditional flow changes skip history; return stack still updates.
// (RULE17) Conditional returns use direction hint; stack supplies target.
// (RULE18) Return stack is a 4-entry circular buffer overwriting oldest.
// (RULE19) Taken calls push the return address.
// (RULE20) Taken returns fetch from top entry and pop it.
// (RULE21) Return target or condition mismatch at return check flushes.
// (RULE22) No underflow or overflow detection on the return stack.
// (RULE23) Link-register move to PC is not treated as a return.
module brp_predictor
    import brp_pkg::*;
#(
    parameter int HIST_ENTRIES = BRP_HIST_ENTRIES,
    parameter int LOOP_MAX = BRP_LOOP_MAX
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [31:0] ctrlWord,
    input wire logic retStackEnable,
    input wire logic pdValid,
    input wire logic [2:0] pdKind,
    input wire logic pdCond,
    input wire logic [31:0] pdPc,
    input wire logic [31:0] pdOffset,
    input wire logic [31:0] pdRegTarget,
    input wire logic pdRegTargetValid,
    input wire logic resValid,
    input wire logic resTaken,
    input wire logic resMispredict,
    input wire logic [31:0] resTarget,
    input wire logic retCheckValid,
    input wire logic retCheckWrong,
    input wire logic [31:0] retCheckTarget,
    output logic fetchRedirect,
    output logic [31:0] fetchAddr,
    output logic predTaken,
    output logic flush,
    output logic flowEnableRead
);
    localparam int HB = $clog2(HIST_ENTRIES);

    initial begin
        if (HIST_ENTRIES != BRP_HIST_ENTRIES || LOOP_MAX != BRP_LOOP_MAX) begin
            $error("table size and loop limit are fixed by field widths");
        end
        if ((1 << HB) != HIST_ENTRIES || HB < 2) begin
            $error("history table size must be a power of two");
        end
        if (LOOP_MAX >= (1 << BRP_LOOP_BITS)) begin
            $error("loop limit does not fit its counter");
        end
    end

    brp_policy_t policy;
    logic loopDisable;
    logic rextDisable;
    logic [HB-1:0] ghr;
    logic [1:0] hint [HIST_ENTRIES];
    logic [1:0] hyst [HIST_ENTRIES];
    logic [HB-1:0] owner [HIST_ENTRIES];
    logic [BRP_LOOP_BITS-1:0] loopCount;
    logic [BRP_LOOP_BITS-1:0] loopTrip;
    logic loopTripValid;
    logic loopSaturated;
    logic resFix;
    logic retFix;
    logic [1:0] curHint;
    logic [31:0] rsTop;
    logic rsPush;
    logic rsPop;
    logic isCall;
    logic isReturn;
    logic dirTaken;
    logic loopExit;
    logic haveTarget;
    logic next_taken;
    logic [31:0] next_target;
    logic [HB-1:0] updIdx;
    logic [HB-1:0] aliasTag;

    // Policy and disables decode straight from the control word
    always_comb begin
        case (ctrlWord[BRP_POLICY_HI:BRP_POLICY_LO])
            2'h1: policy = BRP_POL_TAKEN;
            2'h2: policy = BRP_POL_NOT_TAKEN;
            default: policy = BRP_POL_DYNAMIC; // RULE9
        endcase
        loopDisable = ctrlWord[BRP_LOOP_DIS_BIT]; // RULE10
        rextDisable = ctrlWord[BRP_REXT_DIS_BIT]; // RULE11
    end

    // Classify; a link-register move is plain indirect, never a return
    assign isCall = (pdKind == BRP_K_CALL_IMM) || (pdKind == BRP_K_CALL_REG);
    assign isReturn = (pdKind == BRP_K_RETURN); // RULE23

    // Loop exit predicted when the current run reaches the learned trip
    assign loopExit = !loopDisable && loopTripValid && !loopSaturated &&
                      (loopCount == loopTrip); // RULE4 RULE10

    // Hint read under the current history pattern
    // Table reads are combinational, so prediction costs no extra cycle
    assign curHint = hint[ghr];

    // Direction: unconditional always taken, else policy or history hint
    always_comb begin
        if (!pdCond) begin
            dirTaken = 1'b1; // RULE16
        end else begin
            case (policy)
                BRP_POL_TAKEN: dirTaken = 1'b1; // RULE9
                BRP_POL_NOT_TAKEN: dirTaken = 1'b0; // RULE9 RULE13
                default: dirTaken = curHint[1] && !loopExit; // RULE3 RULE17
            endcase
        end
    end

    // Target selection; unknown target falls back to sequential
    always_comb begin
        haveTarget = 1'b0;
        next_target = pdPc + BRP_SEQ_STEP;
        case (pdKind)
            BRP_K_DIRECT, BRP_K_CALL_IMM: begin
                haveTarget = 1'b1;
                next_target = pdPc + pdOffset; // RULE6
            end
            BRP_K_CALL_REG, BRP_K_INDIRECT, BRP_K_LR_MOVE: begin
                // Register extension cache supplies register targets
                haveTarget = pdRegTargetValid && !rextDisable; // RULE11
                next_target = pdRegTarget;
            end
            BRP_K_RETURN: begin
                haveTarget = retStackEnable; // RULE17 RULE13
                next_target = rsTop; // RULE20
            end
            default: begin
                haveTarget = 1'b0;
                next_target = pdPc + BRP_SEQ_STEP;
            end
        endcase
        next_taken = pdValid && dirTaken && haveTarget; // RULE7
    end

    // Return stack moves on taken calls and returns only
    // A call by register pushes even when its own target is unknown,
    // so the matching return still finds its address
    assign rsPush = pdValid && isCall && dirTaken &&
                    retStackEnable; // RULE19 RULE16
    assign rsPop = pdValid && isReturn && next_taken; // RULE20 RULE16

    brp_return_stack #(
        .DEPTH(BRP_RS_DEPTH),
        .AW(BRP_ADDR_BITS)
    ) uStack (
        .clk(clk),
        .resetn(resetn),
        .push(rsPush),
        .pushAddr(pdPc + BRP_CALL_STEP),
        .pop(rsPop),
        .topAddr(rsTop)
    );

    // Corrections outrank a predecode guess; writeback beats return check
    assign resFix = resValid && resMispredict; // RULE15
    assign retFix = retCheckValid && retCheckWrong; // RULE21

    // Predecode redirect toward the predicted destination
    // A guess that loses to a correction is dropped, not queued, since
    // the refetched stream presents that branch again
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetchRedirect <= 1'b0;
            fetchAddr <= BRP_ADDR_RESET;
            predTaken <= 1'b0;
        end else if (resFix) begin
            fetchRedirect <= 1'b1; // RULE15
            fetchAddr <= resTarget;
            predTaken <= 1'b0;
        end else if (retFix) begin
            fetchRedirect <= 1'b1; // RULE21
            fetchAddr <= retCheckTarget;
            predTaken <= 1'b0;
        end else begin
            fetchRedirect <= next_taken; // RULE14
            fetchAddr <= next_taken ? next_target : pdPc + BRP_SEQ_STEP;
            predTaken <= next_taken;
        end
    end

    // Flush pulses for one cycle on either correction source
    // Stack overflow and underflow surface only through this path
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flush <= 1'b0;
        end else begin
            flush <= resFix || retFix; // RULE15 RULE21 RULE22
        end
    end

    // Enable bit is tied high whatever software writes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flowEnableRead <= 1'b1;
        end else begin
            flowEnableRead <= 1'b1; // RULE12
        end
    end

    // Global history shifts on each resolved conditional outcome
    // Only resolved outcomes enter, so a flushed guess never pollutes it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ghr <= BRP_GHR_RESET;
        end else if (resValid) begin
            ghr <= {ghr[HB-2:0], resTaken}; // RULE1 RULE8
        end
    end

    assign updIdx = ghr;
    // Tag the writer by the current history rotated right by one bit
    assign aliasTag = {ghr[0], ghr[HB-1:1]};

    // Pattern table: saturating hints with alias-triggered hysteresis
    // The entry updated is the one indexed by the history before the
    // outcome shifts in; the tag is rotated from that same history, so it differs
    // from the stored owner only on an entry's first update after reset, and at most one disagreeing update is absorbed before moving
    genvar gi;
    generate
        for (gi = 0; gi < HIST_ENTRIES; gi++) begin : gHint
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    hint[gi] <= BRP_HINT_RESET;
                    hyst[gi] <= BRP_HYST_RESET;
                    owner[gi] <= '0;
                end else if (resValid && updIdx == HB'(gi)) begin // RULE8
                    owner[gi] <= aliasTag;
                    if (owner[gi] != aliasTag && hint[gi][1] != resTaken &&
                        hyst[gi] != 2'h3) begin
                        // Aliased writer disagrees: absorb before moving
                        hyst[gi] <= hyst[gi] + 2'h1; // RULE5
                    end else begin
                        hyst[gi] <= BRP_HYST_RESET;
                        if (resTaken && hint[gi] != 2'h3) begin
                            hint[gi] <= hint[gi] + 2'h1; // RULE3 RULE2
                        end else if (!resTaken && hint[gi] != 2'h0) begin
                            hint[gi] <= hint[gi] - 2'h1; // RULE3
                        end
                    end
                end
            end
        end
    endgenerate

    // Loop counter learns trip count; beyond the limit it saturates
    // A saturated run leaves no valid trip, so long loops are never
    // predicted to exit; one counter serves all loops, nested ones alias
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loopCount <= BRP_LOOP_RESET;
            loopTrip <= BRP_LOOP_RESET;
            loopTripValid <= 1'b0;
            loopSaturated <= 1'b0;
        end else if (resValid) begin
            if (resTaken) begin
                if (loopCount == BRP_LOOP_BITS'(LOOP_MAX)) begin
                    loopSaturated <= 1'b1; // RULE4
                end else begin
                    loopCount <= loopCount + 1'b1;
                end
            end else begin
                loopTrip <= loopCount;
                loopTripValid <= !loopSaturated;
                loopCount <= BRP_LOOP_RESET;
                loopSaturated <= 1'b0;
            end
        end
    end
endmodule : brp_predictor

/* File: verilog/brp_pkg.sv */
// Purpose: Shared constants for the branch and return predictor.
// Assumes: One core clock, asynchronous active-low reset.
// Notes: Policy codes sit in control bits [16:15]; disables at [21], [20].
package brp_pkg;
    localparam int BRP_HIST_ENTRIES = 256;
    localparam int BRP_HIST_BITS = 8;
    localparam int BRP_HINT_BITS = 2;
    localparam int BRP_LOOP_MAX = 31;
    localparam int BRP_LOOP_BITS = 5;
    localparam int BRP_RS_DEPTH = 4;
    localparam int BRP_RS_PTR_BITS = 2;
    localparam int BRP_ADDR_BITS = 32;
    // Control word field positions
    localparam int BRP_POLICY_LO = 15;
    localparam int BRP_POLICY_HI = 16;
    localparam int BRP_LOOP_DIS_BIT = 21;
    localparam int BRP_REXT_DIS_BIT = 20;
    localparam int BRP_FLOW_EN_BIT = 11;
    // Reset values
    localparam logic [1:0] BRP_HINT_RESET = 2'h1;
    localparam logic [7:0] BRP_GHR_RESET = 8'h00;
    localparam logic [4:0] BRP_LOOP_RESET = 5'h00;
    localparam logic [1:0] BRP_HYST_RESET = 2'h0;
    localparam logic [31:0] BRP_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] BRP_SEQ_STEP = 32'h0000_0004;
    localparam logic [31:0] BRP_CALL_STEP = 32'h0000_0004;
    typedef enum logic [1:0] {
        BRP_POL_DYNAMIC = 2'h0,
        BRP_POL_TAKEN = 2'h1,
        BRP_POL_NOT_TAKEN = 2'h2
    } brp_policy_t;
    typedef enum logic [2:0] {
        BRP_K_NONE = 3'h0,
        BRP_K_DIRECT = 3'h1,
        BRP_K_CALL_IMM = 3'h2,
        BRP_K_CALL_REG = 3'h3,
        BRP_K_RETURN = 3'h4,
        BRP_K_INDIRECT = 3'h5,
        BRP_K_LR_MOVE = 3'h6
    } brp_kind_t;
endpackage : brp_pkg

/* File: verilog/brp_return_stack.sv */
// Purpose: Four-entry circular return-address stack.
// Assumes: Push and pop never arrive together from one instruction.
// Notes: No underflow or overflow flag; wrap simply overwrites.
module brp_return_stack
    import brp_pkg::*;
#(
    parameter int DEPTH = BRP_RS_DEPTH,
    parameter int AW = BRP_ADDR_BITS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic push,
    input wire logic [AW-1:0] pushAddr,
    input wire logic pop,
    output logic [AW-1:0] topAddr
);
    localparam int PW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin
            $error("return stack depth must be a power of two");
        end
    end

    logic [AW-1:0] entry [DEPTH];
    logic [PW-1:0] topPtr;

    // Pointer wraps freely; overflow overwrites the oldest entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            topPtr <= '0;
        end else if (push) begin
            topPtr <= topPtr + 1'b1; // RULE18
        end else if (pop) begin
            topPtr <= topPtr - 1'b1; // RULE22
        end
    end

    // Storage written at the slot above the current top
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : gSlot
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    entry[gi] <= BRP_ADDR_RESET;
                end else if (push && (topPtr + 1'b1) == PW'(gi)) begin
                    entry[gi] <= pushAddr; // RULE18
                end
            end
        end
    endgenerate

    assign topAddr = entry[topPtr];
endmodule : brp_return_stack

/* File: testbench/brp_exec_model.sv */
// Purpose: Execute pipeline stand-in that reports branch outcomes.
// Assumes: The bench asks for one report per request pulse.
// Notes: Idle lines invert every cycle, so stale data matches again every second idle cycle.
module brp_exec_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic ck,
    input wire logic wrong,
    input wire logic taken,
    input wire logic [31:0] target,
    output logic resValid,
    output logic resTaken,
    output logic resMispredict,
    output logic [31:0] resTarget,
    output logic retCheckValid,
    output logic retCheckWrong,
    output logic [31:0] retCheckTarget
);
    // Writeback report, one cycle for each request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {resValid, resTaken, resMispredict, resTarget} <= '0;
        end else if (go) begin
            resValid <= 1'b1;
            {resTaken, resMispredict, resTarget} <= {taken, wrong, target};
        end else begin
            resValid <= 1'b0;
            {resTaken, resMispredict} <= ~{resTaken, resMispredict};
            resTarget <= ~resTarget;
        end
    end
    // Return check report; a wrong target forces the correction path
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {retCheckValid, retCheckWrong, retCheckTarget} <= '0;
        end else if (ck) begin
            retCheckValid <= 1'b1;
            {retCheckWrong, retCheckTarget} <= {wrong, target};
        end else begin
            retCheckValid <= 1'b0;
            {retCheckWrong, retCheckTarget} <= ~{retCheckWrong, retCheckTarget};
        end
    end
endmodule : brp_exec_model

/* File: testbench/brp_predictor_checker.sv */
// Purpose: Port assertions for the branch predictor.
// Assumes: One clock; answers land one cycle after a request.
// Notes: Execute overrides beat a predecode request in the same cycle.
module brp_predictor_checker
    import brp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [31:0] ctrlWord,
    input wire logic retStackEnable,
    input wire logic pdValid,
    input wire logic [2:0] pdKind,
    input wire logic pdCond,
    input wire logic [31:0] pdPc,
    input wire logic [31:0] pdOffset,
    input wire logic pdRegTargetValid,
    input wire logic resValid,
    input wire logic resMispredict,
    input wire logic [31:0] resTarget,
    input wire logic retCheckValid,
    input wire logic retCheckWrong,
    input wire logic [31:0] retCheckTarget,
    input wire logic fetchRedirect,
    input wire logic [31:0] fetchAddr,
    input wire logic predTaken,
    input wire logic flush,
    input wire logic flowEnableRead
);
    // Request qualifiers; an override hides the predecode answer
    wire logic resWin = resValid && resMispredict;
    wire logic ckWin = retCheckValid && retCheckWrong;
    wire logic ovr = resWin || ckWin;
    wire logic pdOk = pdValid && !ovr;
    wire logic [1:0] pol = ctrlWord[16:15];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    flow_bit_one_a: assert property (flowEnableRead == 1'b1)
        else $error("flow enable bit not one");
    mispredict_flush_a: assert property (resWin |=>
        flush && fetchRedirect && fetchAddr == $past(resTarget))
        else $error("no flush on mispredict");
    return_check_a: assert property (ckWin && !resWin |=>
        flush && fetchAddr == $past(retCheckTarget))
        else $error("no flush on return check");
    flush_cause_a: assert property (flush |-> $past(ovr))
        else $error("flush without cause");
    taken_redirects_a: assert property (
        predTaken |-> fetchRedirect && !flush && $past(pdValid))
        else $error("taken without redirect");
    direct_target_a: assert property (
        pdOk && pdKind == BRP_K_DIRECT && !pdCond && pol != 2'h2 |=>
        predTaken && fetchAddr == $past(pdPc) + $past(pdOffset))
        else $error("direct target wrong");
    policy_taken_a: assert property (
        pdOk && pdKind == BRP_K_DIRECT && pol == 2'h1 |=> predTaken)
        else $error("taken policy ignored");
    policy_nt_a: assert property (pdOk && pdCond && pol == 2'h2 |=>
        !fetchRedirect && fetchAddr == $past(pdPc) + BRP_SEQ_STEP)
        else $error("not-taken policy ignored");
    no_target_a: assert property (pdOk && !pdRegTargetValid &&
        pdKind inside {BRP_K_INDIRECT, BRP_K_LR_MOVE} |=> !predTaken)
        else $error("taken without target");
    stack_off_a: assert property (pdOk && pdKind == BRP_K_RETURN &&
        !retStackEnable |=> !predTaken)
        else $error("return taken with stack off");
endmodule : brp_predictor_checker

bind brp_predictor brp_predictor_checker brp_predictor_checker_i (
    .clk(clk), .resetn(resetn), .ctrlWord(ctrlWord),
    .retStackEnable(retStackEnable), .pdValid(pdValid), .pdKind(pdKind),
    .pdCond(pdCond), .pdPc(pdPc), .pdOffset(pdOffset),
    .pdRegTargetValid(pdRegTargetValid), .resValid(resValid),
    .resMispredict(resMispredict), .resTarget(resTarget),
    .retCheckValid(retCheckValid), .retCheckWrong(retCheckWrong),
    .retCheckTarget(retCheckTarget), .fetchRedirect(fetchRedirect),
    .fetchAddr(fetchAddr), .predTaken(predTaken), .flush(flush),
    .flowEnableRead(flowEnableRead)
);

/* File: testbench/brp_predictor_tb.sv */
// Purpose: Directed test of the branch and return predictor.
// Assumes: Outputs answer one cycle after each request.
// Notes: Inputs move 2 ns after the rising edge.
module brp_predictor_tb
    import brp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, resetn, retStackEnable, pdValid, pdCond, pdRegTargetValid;
    logic [2:0] pdKind;
    logic [31:0] ctrlWord, pdPc, pdOffset, pdRegTarget, target, stk [5];
    logic go, ck, wrong, taken, resValid, resTaken, resMispredict;
    logic retCheckValid, retCheckWrong, fetchRedirect, predTaken, flush;
    logic flowEnableRead;
    logic [31:0] resTarget, retCheckTarget, fetchAddr;
    int n_mismatch, total_checks, i;
    brp_predictor brp_predictor_i (.clk(clk), .resetn(resetn),
        .ctrlWord(ctrlWord), .retStackEnable(retStackEnable),
        .pdValid(pdValid), .pdKind(pdKind), .pdCond(pdCond), .pdPc(pdPc),
        .pdOffset(pdOffset), .pdRegTarget(pdRegTarget),
        .pdRegTargetValid(pdRegTargetValid), .resValid(resValid),
        .resTaken(resTaken), .resMispredict(resMispredict),
        .resTarget(resTarget), .retCheckValid(retCheckValid),
        .retCheckWrong(retCheckWrong), .retCheckTarget(retCheckTarget),
        .fetchRedirect(fetchRedirect), .fetchAddr(fetchAddr),
        .predTaken(predTaken), .flush(flush),
        .flowEnableRead(flowEnableRead));
    brp_exec_model brp_exec_model_i (.clk(clk), .resetn(resetn), .go(go),
        .ck(ck), .wrong(wrong), .taken(taken), .target(target),
        .resValid(resValid), .resTaken(resTaken),
        .resMispredict(resMispredict), .resTarget(resTarget),
        .retCheckValid(retCheckValid), .retCheckWrong(retCheckWrong),
        .retCheckTarget(retCheckTarget));
    // 40 MHz core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One predecode request; answer sampled after the taking edge
    task pdx(input logic [2:0] k, input logic c, input logic [31:0] pc,
        input logic [31:0] v, input logic et, input logic [31:0] ea);
        @(posedge clk) #2;
        {pdValid, pdKind, pdCond, pdPc} = {1'b1, k, c, pc};
        {pdOffset, pdRegTarget} = {v, v};
        @(posedge clk) #2;
        pdValid = 1'b0;
        chk(predTaken, et);
        chk(fetchRedirect, et);
        chk(fetchAddr, ea);
    endtask : pdx
    // Report through the execute model; c picks the return check
    task rep(input logic c, input logic w, input logic [31:0] a);
        @(posedge clk) #2;
        {go, ck, wrong, taken, target} = {!c, c, w, 1'b1, a};
        @(posedge clk) #2;
        {go, ck} = 2'h0;
        @(posedge clk) #1;
    endtask : rep
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #(25 * 4000);
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        {ctrlWord, retStackEnable, pdValid, pdKind, pdCond, pdPc} = '0;
        {pdOffset, pdRegTarget, pdRegTargetValid} = '0;
        {go, ck, wrong, taken, target} = '0;
        n_mismatch = 0;
        total_checks = 0;
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        chk(flowEnableRead, 1'h1);
        chk(fetchAddr, 32'h0);
        #2 resetn = 1'b1;
        pdx(BRP_K_DIRECT, 0, 32'h100, 32'h40, 1, 32'h140);
        // Every policy code on a conditional branch with weak hints
        for (i = 0; i < 4; i++) begin
            ctrlWord = (32'(i) << 15) | 32'h800;
            pdx(BRP_K_DIRECT, 1, 32'h200, 32'h20, i == 1,
                (i == 1) ? 32'h220 : 32'h204);
        end
        chk(flowEnableRead, 1'h1);
        $display("test policy done");
        // Train one history pattern taken; loop logic held off
        ctrlWord = 32'h0020_0000;
        for (i = 0; i < 16; i++) begin
            rep(0, 0, 32'h300);
            chk(flush, 1'h0);
        end
        pdx(BRP_K_DIRECT, 1, 32'h300, 32'h10, 1, 32'h310);
        $display("test history done");
        // Register targets follow bit 20 under the taken policy
        pdRegTargetValid = 1'b1;
        ctrlWord = 32'h0000_8000;
        pdx(BRP_K_INDIRECT, 1, 32'h400, 32'h800, 1, 32'h800);
        ctrlWord = 32'h0010_8000;
        pdx(BRP_K_INDIRECT, 1, 32'h400, 32'h800, 0, 32'h404);
        pdRegTargetValid = 1'b0;
        ctrlWord = 32'h0000_8000;
        pdx(BRP_K_INDIRECT, 1, 32'h400, 32'h800, 0, 32'h404);
        $display("test register target done");
        // Five calls wrap four slots; the fifth pop wraps unflagged
        ctrlWord = '0;
        retStackEnable = 1'b1;
        for (i = 0; i < 5; i++) begin
            stk[i] = 32'h1000 + (32'(i) << 8);
            pdx(BRP_K_CALL_IMM, 0, stk[i], 32'h40, 1, stk[i] + 32'h40);
        end
        pdx(BRP_K_LR_MOVE, 0, 32'h2000, 32'h0, 0, 32'h2004);
        for (i = 4; i > 0; i--) begin
            pdx(BRP_K_RETURN, 0, 32'h3000, 0, 1, stk[i] + 32'h4);
        end
        pdx(BRP_K_RETURN, 0, 32'h3000, 0, 1, stk[4] + 32'h4);
        ctrlWord = 32'h0001_0000;
        pdx(BRP_K_RETURN, 1, 32'h3000, 0, 0, 32'h3004);
        ctrlWord = 32'h0000_8000;
        pdx(BRP_K_RETURN, 1, 32'h3000, 0, 1, stk[3] + 32'h4);
        retStackEnable = 1'b0;
        ctrlWord = 32'h0001_0000;
        pdx(BRP_K_RETURN, 0, 32'h3000, 0, 0, 32'h3004);
        $display("test return stack done");
        // Corrections from writeback and from the return check
        rep(0, 1, 32'h5000);
        chk(flush, 1'h1);
        chk(fetchAddr, 32'h5000);
        rep(1, 1, 32'h6000);
        chk(flush, 1'h1);
        chk(fetchAddr, 32'h6000);
        $display("test correction done");
        tally_and_finish;
    end
endmodule : brp_predictor_tb
